// *** logic/csa_pkg.sv ***
// Shared constants and carrier types for the console solo arbiter
package csa_pkg;

  // Module counts on the console
  localparam int NCH  = 16;               // Input channel modules
  localparam int NOUT = 8;                // Output sections (group, aux, matrix)
  localparam int NGRP = 8;                // Group master faders

  // Bus geometry
  localparam int AXI_AW = 8;              // Byte address width
  localparam int AXI_DW = 32;             // Data width

  // Register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;  // Option switches
  localparam logic [7:0] REG_STATUS   = 8'h04;  // Arbiter state
  localparam logic [7:0] REG_IN_SOLO  = 8'h08;  // Input solo latches
  localparam logic [7:0] REG_OUT_SOLO = 8'h0c;  // Output solo latches
  localparam logic [7:0] REG_STEREO   = 8'h10;  // Stereo input mask
  localparam logic [7:0] REG_GRP_SOLO = 8'h14;  // Group master solo latches
  localparam logic [7:0] REG_GRP_BASE = 8'h20;  // Group membership, one word each

  // Field positions
  localparam int CTRL_AUTO   = 0;         // Auto-cancel on
  localparam int CTRL_PRIO   = 1;         // Input priority on
  localparam int ST_SIP      = 0;         // Solo-in-place mode active
  localparam int ST_ANY      = 1;         // Any solo active
  localparam int ST_MON      = 2;         // Monitor follows solo bus
  localparam int ST_OUT_HELD = 3;         // Output solo retained but replaced

  // Reset values
  localparam logic [1:0]      CTRL_RST   = 2'h0;
  localparam logic [NCH-1:0]  STEREO_RST = 16'h0000;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing
  localparam longint CLK_HZ       = 50000000;  // Core clock rate
  localparam longint SIP_HOLD_MS  = 2000;      // Mode switch hold time
  localparam int     SIP_HOLD_CYC = int'((SIP_HOLD_MS * CLK_HZ) / 1000);
  localparam int     HOLD_W       = 27;        // Hold counter width

  // Module switch levels as they arrive from the panel
  typedef struct packed {
    logic [NCH-1:0]  chanSolo;            // Channel solo buttons
    logic [NOUT-1:0] outSolo;             // Output solo buttons
    logic [NGRP-1:0] grpSolo;             // Group master solo buttons
    logic [NCH-1:0]  chanSafe;            // Channel mute-safe state
    logic            sipKey;              // Protected mode switch
    logic            clearKey;            // Solo clear button
  } csa_sw_t;

  localparam int SW_W = $bits(csa_sw_t);

  // Drive towards mutes, solo bus and monitor switching
  typedef struct packed {
    logic [NCH-1:0]  chanMute;            // Solo-in-place mutes
    logic [NCH-1:0]  chanListen;          // Channel feeds solo bus
    logic [NCH-1:0]  chanAfl;             // Channel listens after fader
    logic [NCH-1:0]  chanStereo;          // Channel listens in stereo
    logic [NOUT-1:0] outListen;           // Output feeds solo bus (after fader)
    logic            monSolo;             // Monitor and phones take solo bus
    logic            meterSolo;           // Left/right meters take solo bus
    logic            clearLed;            // Solo clear lamp
    logic            sipLed;              // Solo-in-place mode lamp
  } csa_drive_t;

endpackage : csa_pkg

// *** logic/csa_solo_arbiter.sv ***
// Console solo arbiter: switch capture, solo arbitration, mutes, bus slave
//
// Operation
// R1: Solo-in-place mutes every other input channel
// R2: Input solo-in-place leaves monitor on stereo mix
// R3: Further solo or mute-safe lifts solo mute
// R4: Outputs soloed in solo-in-place act as listen
// R5: Mode needs two-second hold; one press cancels
// R6: Clear lamp lit while any solo active
// R7: Clear button cancels every solo in any mode
// R8: Auto-cancel alone leaves only newest solo
// R9: Input priority keeps output solo, replaces audio
// R10: Releasing input solo restores retained output solo
// R11: Both options: inputs cancel inputs, outputs outputs
// R12: Group solo listens to members after fader
// R13: Inputs listen after fader only via group
// R14: Group solo in place solos all members
// R15: Main meters follow solo bus when listening
// R16: One global solo mode for whole console
// R17: Listen solo switches monitor, phones, meters
// R18: Mono/stereo inputs pre-fade, outputs stereo listen
// R19: Clock-counted hold; reset clears requests and options
// R20: Switches synchronised, edge-detected into single toggles
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module csa_solo_arbiter
  import csa_pkg::*;
#(
  parameter int SIP_HOLD = SIP_HOLD_CYC   // Cycles the mode switch must be held
)(
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // Panel switches, asynchronous to the core clock
  input  wire csa_sw_t             panelSw,
  // Mute, solo bus and monitor drive
  output csa_drive_t               drive,
  // AXI4-Lite write address and data
  input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [AXI_DW-1:0]   s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read
  input  wire logic [AXI_AW-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [AXI_DW-1:0]        s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);

  // Switch capture state
  logic [SW_W-1:0]   swMeta_r;             // First sync stage, feeds swSync_r only
  logic [SW_W-1:0]   swSync_r;             // Second sync stage
  logic [SW_W-1:0]   swPrev_r;             // Previous synchronised level
  csa_sw_t           swLvl;                // Synchronised levels
  csa_sw_t           press;                // One-cycle press events

  // Arbitration state
  logic [NCH-1:0]    chanSolo_r, chanSolo_nxt;
  logic [NOUT-1:0]   outSolo_r,  outSolo_nxt;
  logic [NGRP-1:0]   grpSolo_r,  grpSolo_nxt;
  logic              sipMode_r,  sipMode_nxt;
  logic [HOLD_W-1:0] holdCnt_r,  holdCnt_nxt;
  csa_drive_t        drive_nxt;

  // Software-visible settings
  logic [1:0]        ctrl_r,   ctrl_nxt;
  logic [NCH-1:0]    stereo_r, stereo_nxt;
  logic [NCH-1:0]    member_r   [NGRP];    // Channels assigned to each group
  logic [NCH-1:0]    member_nxt [NGRP];

  // Bus slave state
  logic              awGot_r, awGot_nxt;   // Write address captured
  logic [AXI_AW-1:0] awAddr_r, awAddr_nxt;
  logic              wGot_r, wGot_nxt;     // Write data captured
  logic [AXI_DW-1:0] wData_r, wData_nxt;
  logic [3:0]        wStrb_r, wStrb_nxt;
  logic              awReady_nxt, wReady_nxt, bValid_nxt, arReady_nxt, rValid_nxt;
  logic [1:0]        bResp_nxt, rResp_nxt;
  logic [AXI_DW-1:0] rData_nxt;

  // Derived solo picture
  logic [NCH-1:0]    grpIn;                // Channels driven by a group master
  logic [NCH-1:0]    effIn;                // Channels soloed by any route
  logic              anyIn, anyOut, autoOn, prioOn;

  assign swLvl  = csa_sw_t'(swSync_r);
  // R20: rising edge gives one toggle per press
  assign press  = csa_sw_t'(swSync_r & ~swPrev_r);
  assign autoOn = ctrl_r[CTRL_AUTO];
  assign prioOn = ctrl_r[CTRL_PRIO];

  // Panel switches cross into the core clock through two flops
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      swMeta_r <= '0;
      swSync_r <= '0;
      swPrev_r <= '0;
    end
    else
    begin
      // R20: two-stage synchroniser
      swMeta_r <= panelSw;
      swSync_r <= swMeta_r;
      swPrev_r <= swSync_r;
    end
  end

  // Group membership expands a group solo onto its channels
  always_comb
  begin
    grpIn = '0;
    for (int g = 0; g < NGRP; g++)
    begin
      // R12: group solo stands for each member's solo
      if (grpSolo_r[g])
        grpIn = grpIn | member_r[g];
    end
    effIn  = chanSolo_r | grpIn;
    anyIn  = |effIn;
    anyOut = |outSolo_r;
  end

  // Solo latches, auto-cancel, input priority, mode switch
  always_comb
  begin
    logic [NCH-1:0]  chOn;
    logic [NOUT-1:0] outOn;
    logic [NGRP-1:0] grOn;
    logic            newIn, newOut;
    chOn         = press.chanSolo & ~chanSolo_r;
    outOn        = press.outSolo  & ~outSolo_r;
    grOn         = press.grpSolo  & ~grpSolo_r;
    newIn        = |chOn || |grOn;
    newOut       = |outOn;
    // Plain toggle by default
    chanSolo_nxt = chanSolo_r ^ press.chanSolo;
    outSolo_nxt  = outSolo_r  ^ press.outSolo;
    grpSolo_nxt  = grpSolo_r  ^ press.grpSolo;
    if (autoOn && !prioOn)
    begin
      // R8: any new solo drops every earlier one
      if (newIn || newOut)
      begin
        chanSolo_nxt = chOn;
        outSolo_nxt  = outOn;
        grpSolo_nxt  = grOn;
      end
    end
    else if (autoOn && prioOn)
    begin
      // R11: each side cancels only its own kind
      if (newIn)
      begin
        chanSolo_nxt = chOn;
        grpSolo_nxt  = grOn;
      end
      if (newOut)
        outSolo_nxt = outOn;
    end
    // R7: clear button wins over every toggle
    if (press.clearKey)
    begin
      chanSolo_nxt = '0;
      outSolo_nxt  = '0;
      grpSolo_nxt  = '0;
    end
    // R5: hold qualifies entry, one press leaves
    sipMode_nxt = sipMode_r;
    holdCnt_nxt = '0;
    if (sipMode_r)
    begin
      if (press.sipKey)
        sipMode_nxt = 1'b0;
    end
    else if (swLvl.sipKey)
    begin
      // R19: hold measured on the core clock
      if (holdCnt_r == HOLD_W'(SIP_HOLD - 1))
        sipMode_nxt = 1'b1;
      else
        holdCnt_nxt = holdCnt_r + HOLD_W'(1);
    end
  end

  // Drive computation, registered so every output leaves a flop
  always_comb
  begin
    drive_nxt = '0;
    // R16: one mode flag governs every module
    if (sipMode_r)
    begin
      // R1: unsoloed channels muted while any input solos
      // R3: soloed or safe channels stay unmuted
      // R14: group members count as soloed here
      if (anyIn)
        drive_nxt.chanMute = ~effIn & ~swLvl.chanSafe;
      // R4: outputs still listen after fader
      drive_nxt.outListen = outSolo_r;
      // R2: monitor moves only for an output solo
      drive_nxt.monSolo   = anyOut;
    end
    else
    begin
      drive_nxt.chanListen = effIn;
      // R13: after-fade only for group-driven channels
      drive_nxt.chanAfl    = grpIn;
      // R18: stereo for stereo inputs and after-fade listen
      drive_nxt.chanStereo = effIn & (stereo_r | grpIn);
      // R9: input solo replaces output audio under priority
      // R10: output audio returns once inputs are released
      drive_nxt.outListen  = (prioOn && anyIn) ? '0 : outSolo_r;
      // R17: any listen takes monitor and phones
      drive_nxt.monSolo    = anyIn || anyOut;
    end
    // R15: meters follow the monitor switching
    drive_nxt.meterSolo = drive_nxt.monSolo;
    // R6: clear lamp shows any active solo
    drive_nxt.clearLed  = anyIn || anyOut;
    drive_nxt.sipLed    = sipMode_r;
  end

  // Arbitration registers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      // R19: reset drops solos, mode, hold count and drive
      chanSolo_r <= '0;
      outSolo_r  <= '0;
      grpSolo_r  <= '0;
      sipMode_r  <= 1'b0;
      holdCnt_r  <= '0;
      drive      <= '0;
    end
    else
    begin
      chanSolo_r <= chanSolo_nxt;
      outSolo_r  <= outSolo_nxt;
      grpSolo_r  <= grpSolo_nxt;
      sipMode_r  <= sipMode_nxt;
      holdCnt_r  <= holdCnt_nxt;
      drive      <= drive_nxt;
    end
  end

  // Applies byte enables to a register word
  function automatic logic [AXI_DW-1:0] strobe(input logic [AXI_DW-1:0] old,
                                               input logic [AXI_DW-1:0] dat,
                                               input logic [3:0]        be);
    logic [AXI_DW-1:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        res[b*8 +: 8] = dat[b*8 +: 8];
    end
    return res;
  endfunction : strobe

  // Bus slave: address and data taken in either order, one write at a time
  always_comb
  begin
    logic [AXI_DW-1:0] wd;
    logic              hit;
    wd         = '0;
    hit        = 1'b0;
    awGot_nxt  = awGot_r;
    awAddr_nxt = awAddr_r;
    wGot_nxt   = wGot_r;
    wData_nxt  = wData_r;
    wStrb_nxt  = wStrb_r;
    bValid_nxt = s_axi_bvalid && !s_axi_bready;
    bResp_nxt  = s_axi_bresp;
    ctrl_nxt   = ctrl_r;
    stereo_nxt = stereo_r;
    member_nxt = member_r;
    if (s_axi_awvalid && s_axi_awready)
    begin
      awGot_nxt  = 1'b1;
      awAddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      wGot_nxt  = 1'b1;
      wData_nxt = s_axi_wdata;
      wStrb_nxt = s_axi_wstrb;
    end
    // Commit once both halves are in and no response is pending
    if (awGot_r && wGot_r && !s_axi_bvalid)
    begin
      awGot_nxt = 1'b0;
      wGot_nxt  = 1'b0;
      if (awAddr_r == REG_CTRL)
      begin
        wd       = strobe({30'h0, ctrl_r}, wData_r, wStrb_r);
        ctrl_nxt = wd[1:0];
        hit      = 1'b1;
      end
      else if (awAddr_r == REG_STEREO)
      begin
        wd         = strobe({16'h0, stereo_r}, wData_r, wStrb_r);
        stereo_nxt = wd[NCH-1:0];
        hit        = 1'b1;
      end
      for (int g = 0; g < NGRP; g++)
      begin
        if (awAddr_r == REG_GRP_BASE + AXI_AW'(4 * g))
        begin
          wd            = strobe({16'h0, member_r[g]}, wData_r, wStrb_r);
          member_nxt[g] = wd[NCH-1:0];
          hit           = 1'b1;
        end
      end
      bValid_nxt = 1'b1;
      bResp_nxt  = hit ? RESP_OKAY : RESP_SLVERR;
    end
    awReady_nxt = !awGot_nxt && !bValid_nxt;
    wReady_nxt  = !wGot_nxt && !bValid_nxt;
  end

  // Read side: one cycle from address to data
  always_comb
  begin
    rValid_nxt = s_axi_rvalid && !s_axi_rready;
    rData_nxt  = s_axi_rdata;
    rResp_nxt  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rValid_nxt = 1'b1;
      rResp_nxt  = RESP_OKAY;
      rData_nxt  = '0;
      case (s_axi_araddr)
        REG_CTRL:     rData_nxt = {30'h0, ctrl_r};
        REG_STATUS:   rData_nxt = {28'h0, prioOn && anyIn && anyOut && !sipMode_r,
                                   drive.monSolo, anyIn || anyOut, sipMode_r};
        REG_IN_SOLO:  rData_nxt = {16'h0, chanSolo_r};
        REG_OUT_SOLO: rData_nxt = {24'h0, outSolo_r};
        REG_STEREO:   rData_nxt = {16'h0, stereo_r};
        REG_GRP_SOLO: rData_nxt = {24'h0, grpSolo_r};
        default:
        begin
          // Group words, else an unmapped address
          rResp_nxt = RESP_SLVERR;
          for (int g = 0; g < NGRP; g++)
          begin
            if (s_axi_araddr == REG_GRP_BASE + AXI_AW'(4 * g))
            begin
              rData_nxt = {16'h0, member_r[g]};
              rResp_nxt = RESP_OKAY;
            end
          end
        end
      endcase
    end
    // Address is blocked while data waits, so reads never overlap
    arReady_nxt = !rValid_nxt;
  end

  // Bus and settings registers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl_r        <= CTRL_RST;
      stereo_r      <= STEREO_RST;
      member_r      <= '{default: '0};
      awGot_r       <= 1'b0;
      awAddr_r      <= '0;
      wGot_r        <= 1'b0;
      wData_r       <= '0;
      wStrb_r       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      ctrl_r        <= ctrl_nxt;
      stereo_r      <= stereo_nxt;
      member_r      <= member_nxt;
      awGot_r       <= awGot_nxt;
      awAddr_r      <= awAddr_nxt;
      wGot_r        <= wGot_nxt;
      wData_r       <= wData_nxt;
      wStrb_r       <= wStrb_nxt;
      s_axi_awready <= awReady_nxt;
      s_axi_wready  <= wReady_nxt;
      s_axi_bvalid  <= bValid_nxt;
      s_axi_bresp   <= bResp_nxt;
      s_axi_arready <= arReady_nxt;
      s_axi_rvalid  <= rValid_nxt;
      s_axi_rdata   <= rData_nxt;
      s_axi_rresp   <= rResp_nxt;
    end
  end

endmodule : csa_solo_arbiter

// *** tb/csa_solo_chk.sv ***
// Port-level checker for the console solo arbiter
`timescale 1ns/1ps
module csa_solo_chk
  import csa_pkg::*;
#(
  parameter int SIP_HOLD = 10                // Mode switch hold in cycles
)(
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              rst,
  // Panel and drive
  input wire csa_sw_t           panelSw,
  input wire csa_drive_t        drive,
  // Bus answers
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [AXI_DW-1:0] s_axi_rdata
);
  int keyCnt;                                // Current unbroken mode switch run
  int lastRun;                               // Length of the run that just ended
  // The pin is counted raw; a run may end inside the sync stages, so keep the last one
  always_ff @(posedge core_clk)
  begin
    keyCnt  <= panelSw.sipKey ? keyCnt + 1 : 0;
    lastRun <= (!panelSw.sipKey && keyCnt != 0) ? keyCnt : lastRun;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_cancel_press;
    $rose(panelSw.sipKey) && drive.sipLed;
  endsequence
  a_lamp_dark_idle: assert property (
    !drive.clearLed |-> drive.chanListen == '0 && drive.outListen == '0 && drive.chanMute == '0)
    else $error("solo drive active with clear lamp dark");
  a_mon_has_source: assert property (
    drive.monSolo |-> (drive.chanListen != '0 || drive.outListen != '0))
    else $error("monitor on solo bus with nothing soloed");
  a_meter_follows_mon: assert property (
    drive.meterSolo == drive.monSolo) else $error("meters not following monitor feed");
  a_mode_needs_hold: assert property (
    $rose(drive.sipLed) |-> (keyCnt >= SIP_HOLD || lastRun >= SIP_HOLD))
    else $error("mode entered without full hold");
  a_mode_press_cancel: assert property (
    s_cancel_press |-> ##[1:10] !drive.sipLed) else $error("mode not cancelled by press");
  a_sip_no_listen: assert property (
    drive.sipLed && $past(drive.sipLed) |-> drive.chanListen == '0)
    else $error("channel on solo bus in solo-in-place");
  a_mute_only_sip: assert property (
    drive.chanMute != '0 |-> drive.sipLed) else $error("solo mute outside solo-in-place");
  a_safe_never_muted: assert property (
    (drive.chanMute & panelSw.chanSafe & $past(panelSw.chanSafe, 1) & $past(panelSw.chanSafe, 2)
     & $past(panelSw.chanSafe, 3) & $past(panelSw.chanSafe, 4) & $past(panelSw.chanSafe, 5))
     == '0) else $error("mute-safe channel muted");
  a_afl_via_listen: assert property (
    (drive.chanAfl & ~drive.chanListen) == '0) else $error("after-fade bit off the bus");
  a_bresp_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
endmodule : csa_solo_chk

bind csa_solo_arbiter csa_solo_chk #(.SIP_HOLD(SIP_HOLD)) u_chk (.core_clk(core_clk),
  .rst(rst), .panelSw(panelSw), .drive(drive), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// *** tb/csa_panel_model.sv ***
// Panel model: module switch contacts feeding the arbiter
`timescale 1ns/1ps
module csa_panel_model
  import csa_pkg::*;
(
  // Clock
  input  wire logic    core_clk,
  // Operator actions
  input  wire csa_sw_t swCmd,
  // Contact levels
  output csa_sw_t      panelSw
);
  csa_sw_t lvl = '0;                         // Contacts settle one clock late
  // Contacts change off the arbiter's view, like a real panel
  always @(posedge core_clk)
    lvl <= swCmd;
  assign panelSw = lvl;
endmodule : csa_panel_model

// *** tb/testbench.sv ***
// Self-checking bench for the console solo arbiter
`timescale 1ns/1ps
module testbench;
  import csa_pkg::*;
  localparam int HOLD = 10;                  // Shortened mode switch hold
  logic              core_clk = 1'b0;
  logic              rst      = 1'b1;
  csa_sw_t           swCmd    = '0;          // Operator actions
  csa_sw_t           panelSw;
  csa_drive_t        drive;
  logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
  logic [AXI_DW-1:0] wdata  = '0, rdata, d;
  logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp, r;
  logic [NCH-1:0]    m;                      // Group membership under test
  int                n_mismatch = 0, n_tests = 0, seed = 32'h9ee2, a, b, g;
  initial
    forever #10 core_clk = ~core_clk;
  csa_panel_model u_panel (.core_clk(core_clk), .swCmd(swCmd), .panelSw(panelSw));
  csa_solo_arbiter #(.SIP_HOLD(HOLD)) u_dut (.core_clk(core_clk), .rst(rst),
    .panelSw(panelSw), .drive(drive), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic tmo();
    n_mismatch++;
    $display("wait ran out at %0t", $time);
    complete_run();
  endtask : tmo
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Write: both channels offered together, bready held until the answer
  task automatic axw(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] rs);
    int n;
    n = 0;
    awaddr <= ad;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    if (n >= 100)
      tmo();
    rs = bresp;
    bready <= 1'b0;
    // One idle edge, so a following call never reassigns bready in this step
    @(posedge core_clk);
  endtask : axw
  task automatic axr(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    int n;
    n = 0;
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (arready)
        arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    if (n >= 100)
      tmo();
    dt = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge core_clk);
  endtask : axr
  task automatic rdchk(input logic [7:0] ad, input logic [31:0] ex, input logic [1:0] er);
    axr(ad, d, r);
    chk(d, ex);
    chk(r, er);
  endtask : rdchk
  // Press: k 0 channel, 1 output, 2 group, 3 clear, 4 mode switch; held len cycles
  task automatic press(input int k, input int i, input int len);
    case (k)
      0: swCmd.chanSolo[i] <= 1'b1;
      1: swCmd.outSolo[i] <= 1'b1;
      2: swCmd.grpSolo[i] <= 1'b1;
      3: swCmd.clearKey <= 1'b1;
      default: swCmd.sipKey <= 1'b1;
    endcase
    repeat (len) @(posedge core_clk);
    swCmd <= csa_sw_t'({32'h0, swCmd.chanSafe, 2'b00});
    repeat (10) @(posedge core_clk);
  endtask : press
  // Expected solo bus bits: outputs above the channel field
  function automatic logic [31:0] one(input int k, input int i);
    return k ? 32'h1 << (i + 16) : 32'h1 << i;
  endfunction : one
  // Expected solo-in-place mutes
  function automatic logic [15:0] sipMute(input logic [31:0] s, input logic [15:0] safe);
    return (s != '0) ? ~s[15:0] & ~safe : '0;
  endfunction : sipMute
  initial
  begin
    repeat (20000) @(posedge core_clk);
    tmo();
  end
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    rdchk(REG_CTRL, 32'h0, RESP_OKAY);
    rdchk(REG_STEREO, 32'h0, RESP_OKAY);
    rdchk(8'h18, 32'h0, RESP_SLVERR);
    axw(REG_STATUS, 32'hf, r);
    chk(r, RESP_SLVERR);
    // Plain listen: one channel, then an output summed beside it
    a = $unsigned($random(seed)) % NCH;
    b = $unsigned($random(seed)) % NOUT;
    press(0, a, 4);
    chk({drive.outListen, drive.chanListen}, one(0, a));
    chk({drive.monSolo, drive.meterSolo, drive.clearLed}, 3'b111);
    chk({drive.chanStereo, drive.chanAfl}, 32'h0);
    rdchk(REG_IN_SOLO, one(0, a), RESP_OKAY);
    rdchk(REG_STATUS, 32'h6, RESP_OKAY);
    press(1, b, 4);
    chk({drive.outListen, drive.chanListen}, one(0, a) | one(1, b));
    press(3, 0, 4);
    chk({drive.outListen, drive.chanListen, drive.clearLed, drive.monSolo}, 32'h0);
    // Auto-cancel: each new solo leaves only itself
    axw(REG_CTRL, 32'h1, r);
    for (int k = 0; k < 4; k++)
    begin
      a = $unsigned($random(seed)) % 2;
      b = 2 * k + $unsigned($random(seed)) % 2;
      press(a, b, 4);
      chk({drive.outListen, drive.chanListen}, one(a, b));
    end
    press(3, 0, 4);
    // Both options: outputs cancel outputs, inputs replace then restore
    axw(REG_CTRL, 32'h3, r);
    a = $unsigned($random(seed)) % 8;
    press(1, 1, 4);
    press(1, 3, 4);
    chk(drive.outListen, one(0, 3));
    press(0, a, 4);
    press(0, a + 8, 4);
    chk({drive.outListen, drive.chanListen}, one(0, a + 8));
    axr(REG_STATUS, d, r);
    chk(d[ST_OUT_HELD], 1'b1);
    press(0, a + 8, 4);
    chk({drive.outListen, drive.chanListen}, one(1, 3));
    press(3, 0, 4);
    // Priority alone: input replaces output, which returns on release
    axw(REG_CTRL, 32'h2, r);
    press(1, b, 4);
    press(0, a, 4);
    chk({drive.outListen, drive.chanListen}, one(0, a));
    press(0, a, 4);
    chk({drive.outListen, drive.chanListen}, one(1, b));
    press(3, 0, 4);
    // Group solo and stereo inputs
    axw(REG_CTRL, 32'h0, r);
    g = $unsigned($random(seed)) % NGRP;
    m = 16'($random(seed)) | 16'h1;
    axw(REG_GRP_BASE + 8'(4 * g), {16'h0, m}, r);
    press(2, g, 4);
    chk({drive.chanListen, drive.chanAfl}, {m, m});
    chk(drive.chanStereo, m);
    rdchk(REG_GRP_SOLO, one(0, g), RESP_OKAY);
    press(3, 0, 4);
    a = $unsigned($random(seed)) % NCH;
    axw(REG_STEREO, one(0, a), r);
    press(0, a, 4);
    chk(drive.chanStereo, one(0, a));
    press(3, 0, 4);
    // Solo-in-place: short hold refused, full hold taken
    press(4, 0, HOLD - 2);
    chk(drive.sipLed, 1'b0);
    press(4, 0, HOLD + 3);
    chk(drive.sipLed, 1'b1);
    rdchk(REG_STATUS, 32'h1, RESP_OKAY);
    a = $unsigned($random(seed)) % NCH;
    press(0, a, 4);
    chk(drive.chanMute, sipMute(one(0, a), 16'h0));
    chk({drive.chanListen, drive.monSolo}, 32'h0);
    press(0, (a + 1) % NCH, 4);
    chk(drive.chanMute, sipMute(one(0, a) | one(0, (a + 1) % NCH), 16'h0));
    swCmd.chanSafe <= 16'(one(0, (a + 2) % NCH));
    repeat (10) @(posedge core_clk);
    chk(drive.chanMute, sipMute(one(0, a) | one(0, (a + 1) % NCH), swCmd.chanSafe));
    press(1, 5, 4);
    chk({drive.outListen, drive.monSolo, drive.meterSolo}, {8'h20, 2'b11});
    press(3, 0, 4);
    swCmd.chanSafe <= '0;
    chk({drive.chanMute, drive.outListen, drive.clearLed}, 32'h0);
    press(2, g, 4);
    chk({drive.chanMute, drive.chanListen}, {sipMute(m, 16'h0), 16'h0});
    press(3, 0, 4);
    press(4, 0, 4);
    chk(drive.sipLed, 1'b0);
    complete_run();
  end
endmodule : testbench
